// ==== rtl/sfps_seq.sv ====
/*
  Serial flash sequencer: SPI master (mode 0, one data lane) toward the
  configuration flash on chip select zero. Boots by removing protection,
  then serves fast reads, page programs, sector and chip erases.
  Assumes user inputs are synchronous to clk and the flash follows the
  usual single-byte status protocol.
*/
// Contract
// - Single lane, mode 0, auto-increment reads
// - Status bit 0 means flash busy
// - Status bit 1 is write enable latch
// - Only one status byte read or written
// - Always run unprotect sequence at boot
// - Boot: enable, poll latch, write zero
// - Enable and poll latch before program/erase
// - No signature read, fixed protocol
// - Fixed opcodes; three address bytes, none for chip erase
// - SPI clock divisor 5 to 127, rounded down to even
// - Boot flash only on chip select zero
`timescale 1ns/1ns
module sfps_seq
  import sfps_pkg::*;
(
  input  wire logic             clk,          // System clock
  input  wire logic             rst,          // Async reset, high
  input  wire logic [7:0]       clk_div,      // SPI clock divisor
  input  wire logic             req_valid,    // Operation request
  input  wire sfps_op_type      req_op,       // Operation code
  input  wire logic [23:0]      req_addr,     // Flash byte address
  input  wire logic [8:0]       req_len,      // Bytes, read/program
  output logic                  req_ready,    // Ready for request
  input  wire logic [7:0]       wr_data,      // Program data byte
  output logic                  wr_take,      // Program byte taken
  output logic [7:0]            rd_data,      // Read data byte
  output logic                  rd_valid,     // Read byte pulse
  output logic                  boot_done,    // Unprotect complete
  output logic                  busy,         // Sequencer working
  output logic                  spi_clk,      // SPI clock
  output logic                  spi_mosi,     // SPI data out
  input  wire logic             spi_miso,     // SPI data in
  output logic                  flash_chip_select_zero_n // Flash select
);
  typedef struct packed {
    sfps_state_type st;
    sfps_state_type after;    // State entered after the deselect gap
    sfps_op_type    op;
    logic [7:0]     div_cnt;
    logic           phase;    // 0: clock low half, 1: high half
    logic [2:0]     bit_idx;
    logic [1:0]     addr_idx;
    logic [8:0]     remain;
    logic [23:0]    addr;
    logic [7:0]     sh_out;
    logic [7:0]     sh_in;
    logic           cs_n;
    logic           sclk;
    logic           boot_done;
    logic           rd_valid;
    logic           wr_take;
    logic [7:0]     rd_data;
    logic           poll_rd;  // Status byte phase of a poll
  } sfps_regs_type;

  sfps_regs_type cur_r, cur_nxt;
  logic [7:0]    div_eff;
  logic          tick, byte_end;

  // Clamp divisor into its legal range
  function automatic logic [7:0] clamp_div(input logic [7:0] d);
    if (d < DIV_MIN) return DIV_MIN;
    if (d > DIV_MAX) return DIV_MAX;
    return d;
  endfunction

  // Opcode for an operation; no identification command exists
  function automatic logic [7:0] op_code(input sfps_op_type o);
    unique case (o)
      SFPS_OP_READ: return OP_FAST_READ;
      SFPS_OP_PROG: return OP_PAGE_PROG;
      SFPS_OP_SECT: return OP_SECTOR_ERASE;
      SFPS_OP_CHIP: return OP_CHIP_ERASE;
    endcase
  endfunction

  assign div_eff  = clamp_div(clk_div);
  assign tick     = (cur_r.div_cnt == 8'h00);
  // Byte ends on the falling edge after the eighth rising edge
  assign byte_end = tick && cur_r.phase && (cur_r.bit_idx == BIT_LAST);

  // Next-state logic for the whole sequencer
  always_comb begin
    cur_nxt          = cur_r;
    cur_nxt.rd_valid = 1'b0;
    cur_nxt.wr_take  = 1'b0;
    // Divider: each half SPI period spans half the divisor, except the first low half of a frame, which lasts one clock
    if (cur_r.cs_n) begin
      cur_nxt.div_cnt = 8'h00;
    end else if (tick) begin
      cur_nxt.div_cnt = {1'b0, div_eff[7:1]} - 8'h01;
    end else begin
      cur_nxt.div_cnt = cur_r.div_cnt - 8'h01;
    end
    // Mode 0 shift engine: sample on rise, shift on fall
    if (!cur_r.cs_n && tick) begin
      cur_nxt.phase = ~cur_r.phase;
      cur_nxt.sclk  = ~cur_r.phase;
      if (!cur_r.phase) begin
        cur_nxt.sh_in = {cur_r.sh_in[6:0], spi_miso};
      end else begin
        cur_nxt.bit_idx = cur_r.bit_idx + 3'h1;
        cur_nxt.sh_out  = {cur_r.sh_out[6:0], 1'b0};
      end
    end
    unique case (cur_r.st)
      // Boot always assumes the part came up protected
      SFPS_BOOT_WRITE_ENABLE_COMMAND, SFPS_WRITE_ENABLE_COMMAND: begin
        cur_nxt.cs_n   = 1'b0;
        cur_nxt.sh_out = OP_WRITE_ENABLE;
        cur_nxt.bit_idx = 3'h0;
        cur_nxt.phase  = 1'b0;
        cur_nxt.after  = SFPS_POLL_WEL;
        cur_nxt.poll_rd = 1'b0;
        cur_nxt.st     = SFPS_CMD;
      end
      SFPS_CMD: begin
        if (byte_end) begin
          cur_nxt.st   = SFPS_GAP;
          cur_nxt.cs_n = 1'b1;
        end
      end
      // Deselect gap, then the next command of the sequence
      SFPS_GAP: begin
        cur_nxt.cs_n    = 1'b0;
        cur_nxt.bit_idx = 3'h0;
        cur_nxt.phase   = 1'b0;
        cur_nxt.poll_rd = 1'b0;
        cur_nxt.st      = cur_r.after;
        if (cur_r.after == SFPS_POLL_WEL ||
            cur_r.after == SFPS_POLL_BUSY) begin
          cur_nxt.sh_out = OP_STATUS_READ;
        end else if (cur_r.after == SFPS_BOOT_STATUS_WRITE_COMMAND) begin
          cur_nxt.sh_out = OP_STATUS_WRITE;
        end else if (cur_r.after == SFPS_ADDR) begin
          cur_nxt.sh_out = op_code(cur_r.op);
        end else begin
          cur_nxt.cs_n = 1'b1;                           // Back to idle
        end
      end
      // Read one status byte; repeat until the latch is set or busy clears
      SFPS_POLL_WEL, SFPS_POLL_BUSY: begin
        if (byte_end) begin
          if (!cur_r.poll_rd) begin
            cur_nxt.poll_rd = 1'b1;
          end else begin
            cur_nxt.cs_n = 1'b1;
            cur_nxt.st   = SFPS_GAP;
            if (cur_r.st == SFPS_POLL_WEL) begin
              if (cur_nxt.sh_in[ST_WEL_BIT]) begin
                cur_nxt.after = cur_r.boot_done ? SFPS_ADDR
                                                : SFPS_BOOT_STATUS_WRITE_COMMAND;
              end else begin
                cur_nxt.after = SFPS_POLL_WEL;
              end
            end else begin
              cur_nxt.after = cur_nxt.sh_in[ST_BUSY_BIT]
                            ? SFPS_POLL_BUSY : SFPS_IDLE;
            end
          end
        end
      end
      // Single status byte of zero clears every protection bit
      SFPS_BOOT_STATUS_WRITE_COMMAND: begin
        if (byte_end) begin
          if (!cur_r.poll_rd) begin
            cur_nxt.poll_rd = 1'b1;
            cur_nxt.sh_out  = ST_UNPROTECT;
          end else begin
            cur_nxt.cs_n      = 1'b1;
            cur_nxt.boot_done = 1'b1;
            cur_nxt.after     = SFPS_POLL_BUSY;
            cur_nxt.st        = SFPS_GAP;
          end
        end
      end
      SFPS_IDLE: begin
        if (req_valid) begin
          cur_nxt.op       = req_op;
          cur_nxt.addr     = req_addr;
          cur_nxt.addr_idx = 2'h0;
          // Program length capped at one page
          cur_nxt.remain   = (req_len > PAGE_BYTES) ? PAGE_BYTES
                                                    : req_len;
          cur_nxt.after    = SFPS_ADDR;
          cur_nxt.st       = (req_op == SFPS_OP_READ) ? SFPS_GAP
                                                      : SFPS_WRITE_ENABLE_COMMAND;
        end
      end
      // Opcode byte, then three address bytes, high byte first; chip erase stops after the opcode
      SFPS_ADDR: begin
        if (byte_end) begin
          if (!cur_r.poll_rd && cur_r.op == SFPS_OP_CHIP) begin
            cur_nxt.cs_n  = 1'b1;
            cur_nxt.after = SFPS_POLL_BUSY;
            cur_nxt.st    = SFPS_GAP;
          end else if (!cur_r.poll_rd) begin
            cur_nxt.poll_rd = 1'b1;
            cur_nxt.sh_out  = cur_r.addr[23:16];
          end else if (cur_r.addr_idx != ADDR_LAST) begin
            cur_nxt.addr_idx = cur_r.addr_idx + 2'h1;
            cur_nxt.sh_out   = (cur_r.addr_idx == 2'h0)
                             ? cur_r.addr[15:8] : cur_r.addr[7:0];
          end else if (cur_r.op == SFPS_OP_SECT) begin
            cur_nxt.cs_n  = 1'b1;
            cur_nxt.after = SFPS_POLL_BUSY;
            cur_nxt.st    = SFPS_GAP;
          end else if (cur_r.op == SFPS_OP_READ) begin
            cur_nxt.sh_out = 8'h00;
            cur_nxt.st     = SFPS_DUMMY;
          end else begin
            cur_nxt.sh_out  = wr_data;
            cur_nxt.wr_take = 1'b1;
            cur_nxt.remain  = cur_r.remain - 9'h001;
            cur_nxt.st      = SFPS_DATA;
          end
        end
      end
      SFPS_DUMMY: begin
        if (byte_end) cur_nxt.st = SFPS_DATA;
      end
      // Burst: the flash advances its own address
      SFPS_DATA: begin
        if (byte_end) begin
          if (cur_r.op == SFPS_OP_READ) begin
            cur_nxt.rd_data  = cur_nxt.sh_in;
            cur_nxt.rd_valid = 1'b1;
            cur_nxt.remain   = cur_r.remain - 9'h001;
            if (cur_r.remain <= 9'h001) begin
              cur_nxt.cs_n = 1'b1;
              cur_nxt.st   = SFPS_IDLE;
            end
          end else if (cur_r.remain == 9'h000) begin
            cur_nxt.cs_n  = 1'b1;
            cur_nxt.after = SFPS_POLL_BUSY;
            cur_nxt.st    = SFPS_GAP;
          end else begin
            cur_nxt.sh_out  = wr_data;
            cur_nxt.wr_take = 1'b1;
            cur_nxt.remain  = cur_r.remain - 9'h001;
          end
        end
      end
      default: cur_nxt.st = SFPS_IDLE;
    endcase
    if (cur_nxt.cs_n) cur_nxt.sclk = 1'b0;
  end

  // Single state register; reset starts the boot unprotect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_r          <= '0;
      cur_r.st       <= SFPS_BOOT_WRITE_ENABLE_COMMAND;
      cur_r.after    <= SFPS_IDLE;
      cur_r.cs_n     <= 1'b1;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign req_ready = (cur_r.st == SFPS_IDLE);
  assign wr_take   = cur_r.wr_take;
  assign rd_data   = cur_r.rd_data;
  assign rd_valid  = cur_r.rd_valid;
  assign boot_done = cur_r.boot_done;
  assign busy      = (cur_r.st != SFPS_IDLE);
  assign spi_clk   = cur_r.sclk;
  assign spi_mosi  = cur_r.sh_out[7];
  assign flash_chip_select_zero_n = cur_r.cs_n;
endmodule // sfps_seq

// ==== rtl/sfps_pkg.sv ====
/*
  Package for the serial flash protect/program sequencer: opcodes, status
  bit positions, transfer lengths, clock divider limits and state codes.
  Assumes a single 20 MHz system clock domain.
*/
package sfps_pkg;
  // Command opcodes
  localparam logic [7:0] OP_FAST_READ    = 8'h0B;
  localparam logic [7:0] OP_STATUS_READ  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_CHIP_ERASE   = 8'hC7;
  // Status byte layout
  localparam int         ST_BUSY_BIT     = 0;
  localparam int         ST_WEL_BIT      = 1;
  localparam logic [7:0] ST_UNPROTECT    = 8'h00;
  // Page size, divider limits and bit/address counters
  localparam logic [8:0] PAGE_BYTES      = 9'h100;
  localparam logic [7:0] DIV_MIN         = 8'h05;
  localparam logic [7:0] DIV_MAX         = 8'h7F;
  localparam logic [2:0] BIT_LAST        = 3'h7;
  localparam logic [1:0] ADDR_LAST       = 2'h2;
  // User operation codes
  typedef enum logic [1:0] {
    SFPS_OP_READ  = 2'b00,
    SFPS_OP_PROG  = 2'b01,
    SFPS_OP_SECT  = 2'b10,
    SFPS_OP_CHIP  = 2'b11
  } sfps_op_type;
  // Sequencer states
  typedef enum logic [3:0] {
    SFPS_BOOT_WRITE_ENABLE_COMMAND = 4'b0000,
    SFPS_IDLE      = 4'b0001,
    SFPS_WRITE_ENABLE_COMMAND      = 4'b0010,
    SFPS_POLL_WEL  = 4'b0011,
    SFPS_CMD       = 4'b0100,
    SFPS_ADDR      = 4'b0101,
    SFPS_DUMMY     = 4'b0110,
    SFPS_DATA      = 4'b0111,
    SFPS_POLL_BUSY = 4'b1000,
    SFPS_BOOT_STATUS_WRITE_COMMAND = 4'b1001,
    SFPS_GAP       = 4'b1010
  } sfps_state_type;
endpackage

// ==== verification/sfps_seq_chk.sv ====
/* Port checker for the serial flash sequencer.
   Assumes it is bound into sfps_seq and sees its clk and rst. */
`timescale 1ns/1ns
module sfps_seq_chk (
  input wire logic clk,                      // Clock
  input wire logic rst,                      // Reset
  input wire logic req_valid,                // Request
  input wire logic req_ready,                // Ready
  input wire logic rd_valid,                 // Read pulse
  input wire logic wr_take,                  // Take pulse
  input wire logic boot_done,                // Boot done
  input wire logic busy,                     // Busy
  input wire logic spi_clk,                  // SPI clock
  input wire logic spi_mosi,                 // SPI out
  input wire logic flash_chip_select_zero_n  // Select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Clock low outside frames keeps every frame in mode 0
  idle_clk_a: assert property (flash_chip_select_zero_n |-> !spi_clk)
    else $error("spi clock high while deselected");
  half_min_a: assert property ($rose(spi_clk) |=> spi_clk)
    else $error("spi clock high phase too short");
  mosi_hold_a: assert property ($rose(spi_clk) |=> $stable(spi_mosi))
    else $error("mosi moved while clock high");
  ready_boot_a: assert property (req_ready |-> boot_done && !busy)
    else $error("ready before unprotect");
  take_busy_a: assert property (req_valid && req_ready |=> busy)
    else $error("request not started");
  done_hold_a: assert property (boot_done |=> boot_done)
    else $error("boot done dropped");
  rd_pulse_a: assert property (rd_valid |=> !rd_valid)
    else $error("read pulse too long");
  wr_pulse_a: assert property (wr_take |=> !wr_take)
    else $error("take pulse too long");
  c_rd: cover property (rd_valid);
  c_wr: cover property (wr_take);
  c_boot: cover property ($rose(boot_done));
endmodule // sfps_seq_chk
bind sfps_seq sfps_seq_chk sfps_seq_chk_inst (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid),
  .wr_take(wr_take), .boot_done(boot_done), .busy(busy),
  .spi_clk(spi_clk), .spi_mosi(spi_mosi),
  .flash_chip_select_zero_n(flash_chip_select_zero_n));

// ==== verification/sfps_flash_mdl.sv ====
/* Behavioural serial flash: mode 0, one lane, one status byte.
   Assumes a single master; read data counts up from the address low byte. */
`timescale 1ns/1ns
module sfps_flash_mdl (
  input  wire logic       spi_clk,  // SPI clock
  input  wire logic       cs_n,     // Select
  input  wire logic       mosi,     // From master
  output logic            miso,     // To master
  input  wire logic [1:0] wel_lag,  // Slow latch polls
  output logic [7:0]      stat,     // Status byte
  output logic [7:0]      cmd,      // Last command
  output logic [8:0]      clen,     // Its byte count
  output logic [23:0]     addr,     // Its address
  output logic [7:0]      pfirst,   // First page byte
  output logic [7:0]      plast,    // Last page byte
  output logic            bad       // Fault seen
);
  logic [7:0] sh, ob, op;
  logic [8:0] nb;
  logic [2:0] n;
  logic [1:0] wc, bc;
  logic       write_enable_latch_flag, bo;
  initial begin
    stat = 8'hFC; // Powers up protected
    write_enable_latch_flag = 1'b0;
    wc = 2'h0;
    bc = 2'h0;
    bad = 1'b0;
    op = 8'h00;
    bo = 1'b0;
  end
  always @(negedge cs_n) begin
    n = 3'h0;
    nb = 9'h0;
  end
  // Sample on rising edge, whole bytes MSB first
  always @(posedge spi_clk) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    n = n + 3'h1;
    if (n == 3'h0) begin
      if (nb == 9'h0) begin
        op = sh;
        if (bc != 2'h0 && sh != 8'h05) bad = 1'b1;
        if (!write_enable_latch_flag && sh inside {8'h01, 8'h02, 8'h20, 8'hC7}) bad = 1'b1;
        if (!(sh inside {8'h0B, 8'h05, 8'h01, 8'h06, 8'h02, 8'h20, 8'hC7}))
          bad = 1'b1;
        if (sh != 8'h05 && sh != 8'h06) cmd = sh;
      end else if (nb < 9'h4 && op inside {8'h0B, 8'h02, 8'h20})
        addr = {addr[15:0], sh};
      else if (op == 8'h01) stat = sh;
      if (op == 8'h02 && nb == 9'h4) pfirst = sh;
      if (op == 8'h02) plast = sh;
      nb = nb + 9'h1;
    end
  end
  // Busy in bit 0, latch in bit 1; reads count up from the address
  assign ob = (op == 8'h05) ? {stat[7:2], write_enable_latch_flag && wc == 2'h0, bc != 2'h0}
                            : addr[7:0] + nb[7:0] - 8'h05;
  always @(negedge spi_clk) bo = ob[~n];
  assign miso = cs_n ? ~bo : bo; // Released line shows garbage
  always @(posedge cs_n) begin
    if (op == 8'h06) begin
      write_enable_latch_flag = 1'b1;
      wc = wel_lag;
    end
    if (op == 8'h05 && wc != 2'h0) wc = wc - 2'h1;
    if (op == 8'h05 && bc != 2'h0) bc = bc - 2'h1;
    if (op inside {8'h01, 8'h02, 8'h20, 8'hC7}) begin
      write_enable_latch_flag = 1'b0;
      bc = 2'h2;
    end
    if (op == 8'h01 && nb != 9'h2) bad = 1'b1;
    if (op != 8'h05 && op != 8'h06) clen = nb;
  end
endmodule // sfps_flash_mdl

// ==== verification/testbench.sv ====
/* Self-checking bench for sfps_seq against the flash model.
   Assumes a 20 MHz clock and sfps_flash_mdl on select zero. */
`timescale 1ns/1ns
module testbench;
  import sfps_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  clk_div = 8'h05;
  logic        req_valid = 1'b0;
  sfps_op_type req_op = SFPS_OP_READ;
  logic [23:0] req_addr = 24'h0;
  logic [8:0]  req_len = 9'h0;
  logic [7:0]  wr_data = 8'hA5;
  logic [1:0]  wel_lag = 2'h0;
  logic        req_ready, wr_take, rd_valid, boot_done, busy, spi_clk;
  logic        spi_mosi, spi_miso, cs_n, bad;
  logic [7:0]  rd_data, stat, cmd, pfirst, plast;
  logic [23:0] addr;
  logic [8:0]  clen;
  logic [7:0]  rq[$];
  logic [7:0]  dv[3] = '{8'h04, 8'h7F, 8'hC8};
  int          hv[3] = '{2, 63, 63};
  int          err_count = 0, total_checks = 0, k = 0, hcnt = 0, last_h = 0;
  always #25 clk = ~clk;
  sfps_seq sfps_seq_inst (.clk(clk), .rst(rst), .clk_div(clk_div),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_len(req_len), .req_ready(req_ready), .wr_data(wr_data),
    .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .boot_done(boot_done), .busy(busy), .spi_clk(spi_clk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .flash_chip_select_zero_n(cs_n));
  sfps_flash_mdl sfps_flash_mdl_inst (.spi_clk(spi_clk), .cs_n(cs_n),
    .mosi(spi_mosi), .miso(spi_miso), .wel_lag(wel_lag), .stat(stat),
    .cmd(cmd), .clen(clen), .addr(addr), .pfirst(pfirst), .plast(plast),
    .bad(bad));
  // Length of the last SPI clock high phase, in system clocks
  always @(posedge clk) begin
    if (spi_clk) hcnt <= hcnt + 1;
    else if (hcnt != 0) begin
      last_h <= hcnt;
      hcnt <= 0;
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // Bounded wait for idle; gathers read bytes, feeds page bytes
  task automatic wait_ready();
    int i;
    for (i = 0; i < 40000 && req_ready !== 1'b1; i++) begin
      tick();
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (wr_take === 1'b1) begin
        k++;
        wr_data = 8'(k) ^ 8'hA5;
      end
    end
    if (i == 40000) begin
      chk(1'b0, "timeout");
      end_sim();
    end
  endtask
  task automatic do_op(input sfps_op_type o, input logic [23:0] a,
                       input logic [8:0] l);
    k = 0;
    wr_data = 8'hA5;
    rq.delete();
    req_valid = 1'b1;
    req_op = o;
    req_addr = a;
    req_len = l;
    tick();
    req_valid = 1'b0;
    wait_ready();
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    wait_ready();
    chk(stat === 8'h00 && boot_done === 1'b1, "boot unprotect");
    wel_lag = 2'h2;
    do_op(SFPS_OP_PROG, 24'h000100, 9'h12C);
    chk(cmd === 8'h02 && clen === 9'h104, "page length");
    chk(pfirst === 8'hA5 && plast === 8'h5A, "page data");
    chk(addr === 24'h000100, "page address");
    do_op(SFPS_OP_READ, 24'h0012FE, 9'h4);
    chk(rq.size() == 4 && cmd === 8'h0B, "read count");
    foreach (rq[i]) chk(rq[i] === 8'hFE + 8'(i), "read data");
    do_op(SFPS_OP_SECT, 24'h003000, 9'h0);
    chk(cmd === 8'h20 && addr === 24'h003000, "sector erase");
    do_op(SFPS_OP_CHIP, 24'h0, 9'h0);
    chk(cmd === 8'hC7 && clen === 9'h1, "chip erase");
    foreach (dv[i]) begin
      clk_div = dv[i];
      do_op(SFPS_OP_READ, 24'h0, 9'h1);
      chk(last_h == hv[i], "spi clock divider");
    end
    // Second boot with the flash already open: unprotect must still run
    clk_div = 8'h05;
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    wait_ready();
    chk(cmd === 8'h01 && clen === 9'h2 && boot_done === 1'b1, "reboot");
    chk(bad === 1'b0, "flash protocol");
    end_sim();
  end
endmodule // testbench
